//--- logic/tts_defines.svh
`ifndef TTS_DEFINES_SVH
`define TTS_DEFINES_SVH
// Overview of operation
// - Real-trip initiator holds transmitter off for 2 s first.
// - Real-trip initiator then keys trip frequency 2 s, then returns to guard.
// - Loss of channel followed by trip frequency is a test command.
// - Real-trip responder asserts checkback trip and keys trip frequency 2 s.
// - Real-trip initiator treats returned trip as genuine: trip plus checkback.
// - Checkback initiator: off 1.5 s, then trip frequency 0.5 s.
// - Checkback responder: checkback trip, off 2 s, then trip frequency 0.5 s.
// - Checkback initiator answers returned trip with checkback trip only.
// - Three-frequency first exchange: initiator keys high frequency 0.5 s.
// - Three-frequency responder replies with the other frequency 0.5 s after 2 s off.
// - Three-frequency runs a second equivalent exchange for trip 2.
// - Trip 1 is high frequency, trip 2 is low frequency.
// - Trip-received contact energised while trip 1 or trip 2 received.
// - Trip-sent contact energised while trip 1 or trip 2 transmitted.
// - Real-trip mode: all jumpers 2-3, timer 3 s.
// - Two-frequency checkback: jumpers a-c 1-2, d 2-3, timer 7 s.
// - Three-frequency checkback: all jumpers 1-2, timer 7 s.
// - Three-frequency configuration never produces a genuine trip.
// - Receive lamp lit 0.5 s on trip; transmit lamp while keyed.

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TTS_CLK_MHZ 100
`define TTS_MS2CYC(ms) ((ms) * 1000 * `TTS_CLK_MHZ)
`define TTS_T_OFF_REAL_MS 2000
`define TTS_T_KEY_REAL_MS 2000
`define TTS_T_OFF_CB_MS 1500
`define TTS_T_KEY_CB_MS 500
`define TTS_T_RSP_OFF_MS 2000
`define TTS_T_LAMP_MS 500
`define TTS_T_SEC_MS 1000

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
`define TTS_CTRL_OFS 8'h00
`define TTS_CFG_OFS 8'h04
`define TTS_STAT_OFS 8'h08
`define TTS_CTRL_GO 0
`define TTS_CTRL_ABORT 1
`define TTS_CFG_RST 8'h7f
`define TTS_STAT_PASS 8
`define TTS_STAT_FAIL 9

// ------------------------------------------------------------
// Mode straps (bit set = jumper in 1-2, a in bit 0)
// ------------------------------------------------------------
`define TTS_JMP_REAL 4'h0
`define TTS_JMP_CB2 4'h7
`define TTS_JMP_CB3 4'hf
`define TTS_TSET_REAL 4'h3
`define TTS_TSET_CB 4'h7
`endif

//--- logic/tts_pkg.sv
package tts_pkg;
	typedef enum logic [1:0] {TTS_MODE_NONE, TTS_MODE_REAL, TTS_MODE_CB2, TTS_MODE_CB3} tts_mode_t;
	typedef enum logic [2:0] {ST_IDLE, ST_I_OFF, ST_I_KEY, ST_I_WAIT, ST_R_OFF, ST_R_KEY} tts_state_t;
endpackage

//--- logic/tts_tmr_if.sv
`timescale 1ns/10ps
interface tts_tmr_if;
	logic load;
	logic [31:0] load_val;
	logic expired;
	modport ctrl (output load, output load_val, input expired);
	modport tmr (input load, input load_val, output expired);
endinterface

//--- logic/tts_timer.sv
`timescale 1ns/10ps
module tts_timer
	import tts_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	tts_tmr_if.tmr t
);
	logic [31:0] cnt_r;

	// Down counter, expires on its last cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			if (t.load) begin
				cnt_r <= t.load_val;
			end else if (cnt_r != 32'h0000_0000) begin
				cnt_r <= cnt_r - 32'h0000_0001;
			end
		end
	end

	assign t.expired = (cnt_r == 32'h0000_0001) && !t.load;
endmodule

//--- logic/tts_seq.sv
`timescale 1ns/10ps
`include "tts_defines.svh"
module tts_seq
	import tts_pkg::*;
#(
	parameter logic [31:0] T_OFF_REAL = `TTS_MS2CYC(`TTS_T_OFF_REAL_MS),
	parameter logic [31:0] T_KEY_REAL = `TTS_MS2CYC(`TTS_T_KEY_REAL_MS),
	parameter logic [31:0] T_OFF_CB = `TTS_MS2CYC(`TTS_T_OFF_CB_MS),
	parameter logic [31:0] T_KEY_CB = `TTS_MS2CYC(`TTS_T_KEY_CB_MS),
	parameter logic [31:0] T_RSP_OFF = `TTS_MS2CYC(`TTS_T_RSP_OFF_MS),
	parameter logic [31:0] T_LAMP = `TTS_MS2CYC(`TTS_T_LAMP_MS),
	parameter logic [31:0] T_SEC = `TTS_MS2CYC(`TTS_T_SEC_MS)
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic test_initiate_button,
	input wire logic ext_initiate,
	input wire logic rx_loss,
	input wire logic rx_trip_low,
	input wire logic rx_trip_high,
	output logic tx_off,
	output logic tx_key_low,
	output logic tx_key_high,
	output logic trip_out,
	output logic checkback_trip,
	output logic trip_sent_contact,
	output logic trip_received_contact,
	output logic led_rx_trip,
	output logic led_tx_trip
);
	tts_tmr_if tif();
	tts_state_t st_r;
	tts_mode_t mode;
	logic [7:0] cfg_r;
	logic [7:0] aph_a_r;
	logic aph_wr_r;
	logic go_r;
	logic abort_r;
	logic pass_r;
	logic fail_r;
	logic pass_set;
	logic fail_set;
	logic init_d_r;
	logic init_evt;
	logic rt_d_r;
	logic rt_rise;
	logic los_r;
	logic ret_pend_r;
	logic cmd_evt;
	logic ret_evt;
	logic exch_r;
	logic key_hi_r;
	logic real_r;
	logic ld_r;
	logic [31:0] ldv_r;
	logic [31:0] lamp_r;
	logic rcg;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	logic tx_off_r;
	logic tx_key_low_r;
	logic tx_key_high_r;
	logic trip_out_r;
	logic checkback_trip_r;
	logic trip_sent_r;
	logic trip_rcv_r;
	logic led_rx_r;
	logic led_tx_r;
	logic keying;
	logic [31:0] rd_mux;

	// ------------------------------------------------------------
	// Timer
	// ------------------------------------------------------------
	assign tif.load = ld_r;
	assign tif.load_val = ldv_r;

	tts_timer u_tmr (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.t(tif.tmr)
	);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// Jumper pattern and timer setting together pick the mode
	always_comb begin
		mode = TTS_MODE_NONE;
		if (cfg_r[3:0] == `TTS_JMP_REAL && cfg_r[7:4] == `TTS_TSET_REAL) begin
			mode = TTS_MODE_REAL;
		end else if (cfg_r[3:0] == `TTS_JMP_CB2 && cfg_r[7:4] == `TTS_TSET_CB) begin
			mode = TTS_MODE_CB2;
		end else if (cfg_r[3:0] == `TTS_JMP_CB3 && cfg_r[7:4] == `TTS_TSET_CB) begin
			mode = TTS_MODE_CB3;
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr[7:0])
			`TTS_CTRL_OFS: rd_mux = 32'h0000_0000;
			`TTS_CFG_OFS: rd_mux = {24'h00_0000, cfg_r};
			`TTS_STAT_OFS: rd_mux = {22'h00_0000, fail_r, pass_r, 2'b00, st_r, mode, ld_r | (st_r != ST_IDLE)};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_wr_r <= 1'b0;
			aph_a_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			hreadyout_r <= 1'b0;
		end else if (ce) begin
			hreadyout_r <= 1'b1;
			aph_wr_r <= hsel && hready && htrans[1] && hwrite;
			aph_a_r <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	// Data phase writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r <= `TTS_CFG_RST;
			go_r <= 1'b0;
			abort_r <= 1'b0;
		end else if (ce) begin
			go_r <= aph_wr_r && aph_a_r == `TTS_CTRL_OFS && hwdata[`TTS_CTRL_GO];
			abort_r <= aph_wr_r && aph_a_r == `TTS_CTRL_OFS && hwdata[`TTS_CTRL_ABORT];
			if (aph_wr_r && aph_a_r == `TTS_CFG_OFS) begin
				cfg_r <= hwdata[7:0];
			end
		end
	end

	// Sticky result flags, set beats write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pass_r <= 1'b0;
			fail_r <= 1'b0;
		end else if (ce) begin
			if (pass_set) begin
				pass_r <= 1'b1;
			end else if (aph_wr_r && aph_a_r == `TTS_STAT_OFS && hwdata[`TTS_STAT_PASS]) begin
				pass_r <= 1'b0;
			end
			if (fail_set) begin
				fail_r <= 1'b1;
			end else if (aph_wr_r && aph_a_r == `TTS_STAT_OFS && hwdata[`TTS_STAT_FAIL]) begin
				fail_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Channel event tracking
	// ------------------------------------------------------------
	assign init_evt = ((test_initiate_button || ext_initiate) && !init_d_r) || go_r;
	assign rt_rise = (rx_trip_low || rx_trip_high) && !rt_d_r;
	assign cmd_evt = st_r == ST_IDLE && !ld_r && los_r && rt_rise;
	// Return may rise while still keyed; held pending until the wait state
	assign ret_evt = st_r == ST_I_WAIT && !ld_r && (ret_pend_r || (rt_rise && (los_r || mode == TTS_MODE_REAL)));
	assign rcg = cmd_evt || ret_evt;
	assign pass_set = ret_evt && (mode != TTS_MODE_CB3 || exch_r);
	assign fail_set = st_r == ST_I_WAIT && tif.expired && !ld_r && !ret_evt;

	// Loss seen, cleared once guard returns
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_d_r <= 1'b0;
			rt_d_r <= 1'b0;
			los_r <= 1'b0;
			ret_pend_r <= 1'b0;
		end else if (ce) begin
			if (ret_evt || (st_r != ST_I_KEY && st_r != ST_I_WAIT)) begin
				ret_pend_r <= 1'b0;
			end else if (rt_rise && (los_r || mode == TTS_MODE_REAL)) begin
				ret_pend_r <= 1'b1;
			end
			init_d_r <= test_initiate_button || ext_initiate;
			rt_d_r <= rx_trip_low || rx_trip_high;
			if (rx_loss) begin
				los_r <= 1'b1;
			end else if (!rx_trip_low && !rx_trip_high) begin
				los_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Sequence state machine
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= ST_IDLE;
			ld_r <= 1'b0;
			ldv_r <= 32'h0000_0000;
			exch_r <= 1'b0;
			key_hi_r <= 1'b0;
		end else if (ce) begin
			ld_r <= 1'b0;
			if (abort_r) begin
				st_r <= ST_IDLE;
			end else if (!ld_r) begin
				unique case (st_r)
					ST_IDLE: begin
						if (cmd_evt && mode != TTS_MODE_NONE) begin
							// Reply with the other frequency in three-frequency mode
							key_hi_r <= mode == TTS_MODE_CB3 && rx_trip_low;
							ld_r <= 1'b1;
							if (mode == TTS_MODE_REAL) begin
								st_r <= ST_R_KEY;
								ldv_r <= T_KEY_REAL;
							end else begin
								st_r <= ST_R_OFF;
								ldv_r <= T_RSP_OFF;
							end
						end else if (init_evt && mode != TTS_MODE_NONE) begin // Initiate only from idle
							st_r <= ST_I_OFF;
							exch_r <= 1'b0;
							ld_r <= 1'b1;
							ldv_r <= mode == TTS_MODE_REAL ? T_OFF_REAL : T_OFF_CB;
						end
					end
					ST_I_OFF: begin
						if (tif.expired) begin
							st_r <= ST_I_KEY;
							key_hi_r <= mode == TTS_MODE_CB3 && !exch_r;
							ld_r <= 1'b1;
							ldv_r <= mode == TTS_MODE_REAL ? T_KEY_REAL : T_KEY_CB;
						end
					end
					ST_I_KEY: begin
						if (tif.expired) begin
							// Back to guard, sequence timer bounds the wait
							st_r <= ST_I_WAIT;
							ld_r <= 1'b1;
							ldv_r <= 32'(32'(cfg_r[7:4]) * T_SEC);
						end
					end
					ST_I_WAIT: begin
						if (ret_evt && mode == TTS_MODE_CB3 && !exch_r) begin
							st_r <= ST_I_OFF;
							exch_r <= 1'b1;
							ld_r <= 1'b1;
							ldv_r <= T_OFF_CB;
						end else if (ret_evt || tif.expired) begin
							st_r <= ST_IDLE;
						end
					end
					ST_R_OFF: begin
						if (tif.expired) begin
							st_r <= ST_R_KEY;
							ld_r <= 1'b1;
							ldv_r <= T_KEY_CB;
						end
					end
					ST_R_KEY: begin
						if (tif.expired) begin
							st_r <= ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Recognition lamp and trip outputs
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lamp_r <= 32'h0000_0000;
			real_r <= 1'b0;
		end else if (ce) begin
			if (rcg) begin
				lamp_r <= T_LAMP;
				// Genuine trip only for real-trip initiator
				real_r <= ret_evt && mode == TTS_MODE_REAL;
			end else if (lamp_r != 32'h0000_0000) begin
				lamp_r <= lamp_r - 32'h0000_0001;
			end
		end
	end

	assign keying = st_r == ST_I_KEY || st_r == ST_R_KEY;

	// Registered output drivers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_off_r <= 1'b0;
			tx_key_low_r <= 1'b0;
			tx_key_high_r <= 1'b0;
			trip_out_r <= 1'b0;
			checkback_trip_r <= 1'b0;
			trip_sent_r <= 1'b0;
			trip_rcv_r <= 1'b0;
			led_rx_r <= 1'b0;
			led_tx_r <= 1'b0;
		end else if (ce) begin
			tx_off_r <= st_r == ST_I_OFF || st_r == ST_R_OFF;
			tx_key_low_r <= keying && !key_hi_r;
			tx_key_high_r <= keying && key_hi_r;
			checkback_trip_r <= lamp_r != 32'h0000_0000;
			trip_out_r <= lamp_r != 32'h0000_0000 && real_r && mode == TTS_MODE_REAL;
			trip_sent_r <= keying;
			trip_rcv_r <= rx_trip_low || rx_trip_high;
			led_rx_r <= lamp_r != 32'h0000_0000;
			led_tx_r <= keying;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign tx_off = tx_off_r;
	assign tx_key_low = tx_key_low_r;
	assign tx_key_high = tx_key_high_r;
	assign trip_out = trip_out_r;
	assign checkback_trip = checkback_trip_r;
	assign trip_sent_contact = trip_sent_r;
	assign trip_received_contact = trip_rcv_r;
	assign led_rx_trip = led_rx_r;
	assign led_tx_trip = led_tx_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_idle_go;
		st_r == ST_IDLE && !ld_r && !abort_r && !cmd_evt && init_evt && mode != TTS_MODE_NONE && ce;
	endsequence

	property p_real_off;
		s_idle_go and mode == TTS_MODE_REAL |=> ld_r && ldv_r == T_OFF_REAL && st_r == ST_I_OFF;
	endproperty
	a_real_off: assert property (p_real_off) else $error("real off time wrong");

	property p_cb_off;
		s_idle_go and mode != TTS_MODE_REAL |=> ld_r && ldv_r == T_OFF_CB;
	endproperty
	a_cb_off: assert property (p_cb_off) else $error("checkback off time wrong");

	property p_off_pin;
		ce && st_r == ST_I_OFF && $past(ce) |=> tx_off && !tx_key_low && !tx_key_high;
	endproperty
	a_off_pin: assert property (p_off_pin) else $error("transmitter not off");

	property p_cmd_needs_loss;
		ce && st_r == ST_IDLE && !ld_r && !abort_r ##1 st_r == ST_R_OFF || st_r == ST_R_KEY |-> $past(los_r);
	endproperty
	a_cmd_needs_loss: assert property (p_cmd_needs_loss) else $error("command without loss");

	property p_no_real_3f;
		mode == TTS_MODE_CB3 |-> ##1 !trip_out;
	endproperty
	a_no_real_3f: assert property (p_no_real_3f) else $error("genuine trip in 3f");

	property p_trip_only_real;
		$rose(trip_out) |-> checkback_trip && $past(real_r);
	endproperty
	a_trip_only_real: assert property (p_trip_only_real) else $error("trip without cause");

	property p_rcv_contact;
		ce |=> trip_received_contact == $past(rx_trip_low || rx_trip_high);
	endproperty
	a_rcv_contact: assert property (p_rcv_contact) else $error("rx contact wrong");

	property p_sent_contact;
		ce |=> trip_sent_contact == $past(keying) && led_tx_trip == trip_sent_contact;
	endproperty
	a_sent_contact: assert property (p_sent_contact) else $error("tx contact wrong");

	property p_busy_ignore;
		ce && st_r != ST_IDLE && !abort_r && !(st_r == ST_I_WAIT && ret_evt) |=> st_r != ST_I_OFF || $past(st_r) == ST_I_OFF;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("restart while busy");

	property p_lamp_load;
		ce && rcg |=> lamp_r == T_LAMP;
	endproperty
	a_lamp_load: assert property (p_lamp_load) else $error("lamp time wrong");

	property p_3f_first_hi;
		ce && st_r == ST_I_OFF && mode == TTS_MODE_CB3 && !exch_r && tif.expired && !ld_r && !abort_r
			|=> ##1 tx_key_high && !tx_key_low;
	endproperty
	a_3f_first_hi: assert property (p_3f_first_hi) else $error("first key not high");
endmodule

//--- verification/tts_remote_model.sv
`timescale 1ns/10ps
module tts_remote_model #(
	parameter int T_OFF_REAL = 40,
	parameter int T_KEY_REAL = 40,
	parameter int T_OFF_CB = 30,
	parameter int T_KEY_CB = 10,
	parameter int T_RSP_OFF = 40
)
(
	input wire logic hclk,
	input wire logic [1:0] mode,
	input wire logic start,
	input wire logic mute,
	input wire logic [7:0] gap,
	input wire logic tx_off,
	input wire logic tx_key_low,
	input wire logic tx_key_high,
	output logic rx_loss,
	output logic rx_trip_low,
	output logic rx_trip_high
);
	logic seen;
	logic hi;

	// Far transmitter off for off cycles (none when off is 0), then keyed to one trip frequency
	task automatic send(input int off, input int key, input logic h);
		if (off > 0) begin
			rx_loss <= 1'b1;
			repeat (off) @(posedge hclk);
		end
		rx_loss <= 1'b0;
		rx_trip_low <= !h;
		rx_trip_high <= h;
		repeat (key) @(posedge hclk);
		rx_trip_low <= 1'b0;
		rx_trip_high <= 1'b0;
	endtask

	// Far test unit: initiate on start, otherwise answer commands
	initial begin
		rx_loss = 1'b0;
		rx_trip_low = 1'b0;
		rx_trip_high = 1'b0;
		seen = 1'b0;
		forever begin
			@(posedge hclk);
			if (start) begin
				if (mode == 2'd1) send(T_OFF_REAL, T_KEY_REAL, 1'b0);
				else send(T_OFF_CB, T_KEY_CB, mode == 2'd3);
				repeat (T_RSP_OFF + T_KEY_CB + 20) @(posedge hclk);
				seen = 1'b0;
			end else if (tx_off) begin
				seen = 1'b1;
			end else if (seen && (tx_key_low || tx_key_high)) begin
				hi = tx_key_low && mode == 2'd3;
				seen = 1'b0;
				repeat (gap) @(posedge hclk);
				if (!mute && mode == 2'd1) send(0, T_KEY_REAL, 1'b0);
				else if (!mute) send(T_RSP_OFF, T_KEY_CB, hi);
			end
		end
	end
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	import tts_pkg::*;
	localparam int TOR = 40;
	localparam int TOC = 30;
	localparam int TKC = 10;
	localparam int TL = 10;
	localparam int TSEC = 20;
	logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, button, ext, rstart, rmute;
	logic [1:0] htrans, rmode;
	logic [2:0] hsize;
	logic [7:0] rgap;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic rx_loss, rx_trip_low, rx_trip_high, tx_off, tx_key_low, tx_key_high;
	logic trip_out, checkback_trip, trip_sent_contact, trip_received_contact, led_rx_trip, led_tx_trip;
	logic rx_q;
	int errors, samples_checked, tno;

	tts_seq #(.T_OFF_REAL(TOR), .T_KEY_REAL(TOR), .T_OFF_CB(TOC), .T_KEY_CB(TKC), .T_RSP_OFF(TOR), .T_LAMP(TL),
		.T_SEC(TSEC)) tts_seq_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .test_initiate_button(button),
		.ext_initiate(ext), .rx_loss(rx_loss), .rx_trip_low(rx_trip_low), .rx_trip_high(rx_trip_high),
		.tx_off(tx_off), .tx_key_low(tx_key_low), .tx_key_high(tx_key_high), .trip_out(trip_out),
		.checkback_trip(checkback_trip), .trip_sent_contact(trip_sent_contact),
		.trip_received_contact(trip_received_contact), .led_rx_trip(led_rx_trip), .led_tx_trip(led_tx_trip));
	tts_remote_model tts_remote_model_i (.hclk(hclk), .mode(rmode), .start(rstart), .mute(rmute), .gap(rgap),
		.tx_off(tx_off), .tx_key_low(tx_key_low), .tx_key_high(tx_key_high), .rx_loss(rx_loss),
		.rx_trip_low(rx_trip_low), .rx_trip_high(rx_trip_high));

	// ------------------------------------------------------------
	// Compare and report
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Count of n phases of t cycles, one load cycle of slack each
	task automatic chk_cnt(input int c, input int n, input int t);
		samples_checked++;
		if (c < n * t || c > n * (t + 1)) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, c, n * t);
		end
	endtask

	task automatic results;
		$display("comparisons=%0d mismatches=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus master
	// ------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 200);
		rd = hrdata;
		if (n >= 200) begin
			errors++;
			results();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] r;
		xfer(1'b1, a, wd, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask

	// ------------------------------------------------------------
	// One test sequence, watched at the line side
	// ------------------------------------------------------------
	task automatic run(input logic [7:0] cfg, input int how, input int offn, input int offt, input int keyt,
		input int lon, input int hin, input logic [1:0] tc, input int lampn, input logic [31:0] exs,
		input logic [31:0] msk);
		int off, lo, hi, lamp, ov, n;
		logic [1:0] seen;
		off = 0;
		lo = 0;
		hi = 0;
		lamp = 0;
		ov = 0;
		seen = 2'b00;
		rmode <= (cfg == 8'h7f) ? 2'd3 : (cfg == 8'h77) ? 2'd2 : 2'd1;
		wr(8'h04, {24'h0, cfg});
		if (how == 0) button <= 1'b1;
		if (how == 1) ext <= 1'b1;
		if (how == 2) wr(8'h00, 32'h1);
		if (how == 3) rstart <= 1'b1;
		for (n = 0; n < 400; n++) begin
			@(posedge hclk);
			button <= (n == 20 && how < 3);
			ext <= 1'b0;
			rstart <= 1'b0;
			off += tx_off;
			lo += tx_key_low;
			hi += tx_key_high;
			lamp += led_rx_trip;
			ov += tx_off & (tx_key_low | tx_key_high);
			seen |= {trip_out, checkback_trip};
		end
		chk_cnt(off, offn, offt);
		chk_cnt(lo, lon, keyt);
		chk_cnt(hi, hin, keyt);
		chk(ov, 0);
		chk({30'h0, seen}, {30'h0, tc});
		chk_cnt(lamp, lampn, TL);
		n = 0;
		do begin
			xfer(1'b0, 8'h08, 32'h0, d);
			n++;
		end while (d[0] !== 1'b0 && n < 50);
		if (n >= 50) begin
			errors++;
			results();
		end
		chk(d & msk, exs);
		wr(8'h08, 32'h300);
		xfer(1'b0, 8'h08, 32'h0, d);
		chk(d & 32'h300, 32'h0);
		tno++;
		$display("test %0d finished", tno);
	endtask

	// Sent contact and lamp track the key pins; received contact one cycle behind reception
	always @(posedge hclk) begin
		if (hresetn) begin
			chk({29'h0, trip_sent_contact, trip_received_contact, led_tx_trip},
				{29'h0, tx_key_low | tx_key_high, rx_q, tx_key_low | tx_key_high});
		end
		rx_q <= rx_trip_low | rx_trip_high;
	end

	// Clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Main sequence
	initial begin
		{hresetn, hsel, hwrite, button, ext, rstart, rmute, rx_q} = '0;
		ce = 1'b1;
		{htrans, rmode, rgap} = '0;
		hsize = 3'b010;
		{haddr, hwdata} = '0;
		errors = 0;
		samples_checked = 0;
		tno = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rd(8'h04, 32'h7f);
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h6);
		wr(8'h0c, 32'hffff);
		rd(8'h0c, 32'h0);
		ce <= 1'b0;
		wr(8'h04, 32'h30);
		ce <= 1'b1;
		rd(8'h04, 32'h7f);
		run(8'h30, 0, 1, TOR, 40, 1, 0, 2'b11, 1, 32'h102, 32'h3ff);
		run(8'h77, 1, 1, TOC, TKC, 1, 0, 2'b01, 1, 32'h104, 32'h3ff);
		run(8'h7f, 2, 2, TOC, TKC, 1, 1, 2'b01, 2, 32'h106, 32'h3ff);
		run(8'h30, 3, 0, TOR, 40, 1, 0, 2'b01, 1, 32'h2, 32'h3f);
		run(8'h7f, 3, 1, 40, TKC, 1, 0, 2'b01, 1, 32'h6, 32'h3f);
		run(8'h00, 0, 0, 1, 1, 0, 0, 2'b00, 0, 32'h0, 32'h3ff);
		rgap <= 8'd30;
		run(8'h77, 0, 1, TOC, TKC, 1, 0, 2'b01, 1, 32'h104, 32'h3ff);
		rmute <= 1'b1;
		run(8'h30, 1, 1, TOR, 40, 1, 0, 2'b00, 0, 32'h202, 32'h3ff);
		rmute <= 1'b0;
		wr(8'h00, 32'h1);
		repeat (5) @(posedge hclk);
		wr(8'h00, 32'h2);
		repeat (2) @(posedge hclk);
		rd(8'h08, 32'h2);
		results();
	end
endmodule
